// ### hdl/trig_out_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes a 20 MHz system clock and a nanosecond system time
`ifndef TRIG_OUT_REGS_SVH
`define TRIG_OUT_REGS_SVH

// ==========================================================
// clock and time units
`define TRIG_CLK_MHZ 20
`define TRIG_CLK_NS (1000 / `TRIG_CLK_MHZ)
`define TRIG_PULSE_UNIT_SHIFT 3
`define TRIG_PATTERN_BITS 16

// ==========================================================
// byte offsets
`define TRIG_OFS_CFG 8'h00
`define TRIG_OFS_TARGET 8'h04
`define TRIG_OFS_CYCW 8'h08
`define TRIG_OFS_PAT 8'h0C
`define TRIG_OFS_PULW 8'h10
`define TRIG_OFS_CTRL 8'h14
`define TRIG_OFS_RUNS 8'h18

// ==========================================================
// field positions
`define TRIG_CFG_CHAIN 31
`define TRIG_CFG_TAIL 30
`define TRIG_CFG_NOW 25
`define TRIG_CFG_WAVE_HI 22
`define TRIG_CFG_WAVE_LO 20
`define TRIG_CFG_PIN 16
`define TRIG_CFG_ITER_HI 15
`define TRIG_CTRL_ARM 0
`define TRIG_CTRL_CLR 1

// ==========================================================
// reset values
`define TRIG_RST_WORD 32'h0000_0000
`define TRIG_RST_HALF 16'h0000

`endif

// ### hdl/trig_out_pkg.sv
// types shared by the timed trigger output unit
// assumes nothing of its surroundings
package trig_out_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_RUN = 3'h2,
        ST_DONE = 3'h4
    } unit_state_t;

    typedef enum logic [2:0] {
        WV_FALL = 3'h0,
        WV_RISE = 3'h1,
        WV_NPULSE = 3'h2,
        WV_PPULSE = 3'h3,
        WV_NPER = 3'h4,
        WV_PPER = 3'h5,
        WV_PATTERN = 3'h6,
        WV_RSVD = 3'h7
    } wave_sel_t;
endpackage

// ### hdl/timed_trigger_waveform_output.sv
// one timed trigger output unit with an apb register slave
// assumes systime_i is a nanosecond counter on clk_i and that
// neighbouring units feed their pin levels in on the same clock
//
// Functional notes
// R01: waveform starts only when armed and system time has reached target time.
// R02: code 000 drops the high idle output low once, stays low.
// R03: code 001 raises the output once and it stays high.
// R04: code 010 gives one low pulse from high idle, then high.
// R05: code 011 gives one high pulse from low idle, then low.
// R06: code 100 periodic, low phase from width, cycles counted, zero endless.
// R07: code 101 periodic, high phase from width, cycles counted, zero endless.
// R08: code 110 shifts 16-bit pattern msb first, looped, bit count ends.
// R09: software never programs code 111.
// R10: software keeps output toggling at or below 12.5 MHz.
// R11: bit 16 picks second pin when one, first pin when zero.
// R12: units sharing a pin are ORed onto it.
// R13: chained tail unit repeats the pattern iteration field plus one times.
// R14: chain without a tail repeats the pattern forever.
// R15: pulse width counts in 8 ns steps.
// R16: cycle width and bit width count in 1 ns steps.
// R17: trigger-now fires at once when target already lies in the past.
// R18: software stops an endless chain by the unit soft clear.
// R19: after a finite waveform the output holds its final idle level.
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "trig_out_regs.svh"

module timed_trigger_waveform_output (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [31:0] systime_i,
    input wire logic chain_tail_present_i,
    input wire logic other_pin1_i,
    input wire logic other_pin2_i,
    output logic gpio1_o,
    output logic gpio2_o
);

    localparam logic [31:0] CLK_NS = 32'(`TRIG_CLK_NS);

    // ==========================================================
    // registers
    logic chain_enable_r, tail_r, trig_now_r, pin_sel_r, unit_arm_r, pready_r, pslverr_r;
    trig_out_pkg::wave_sel_t wave_sel_r;
    logic [15:0] iter_r, cnt_r, pat_r, pulw_r;
    logic [31:0] target_r, cycw_r, prdata_r;

    trig_out_pkg::unit_state_t st_r, st_nxt;
    logic wave_r, wave_nxt, phase_r, phase_nxt, gpio1_r, gpio2_r;
    logic [3:0] idx_r, idx_nxt;
    logic [31:0] acc_r, acc_nxt, runs_r, runs_nxt, prev_sys_r;

    // ==========================================================
    // apb slave: one wait state, writes land on the completing edge
    logic xfer, wr, known, clr_pulse, cfg_wr, ctrl_wr;
    logic [31:0] rd_word;

    assign xfer = psel_i & penable_i & pready_r;
    assign wr = xfer & pwrite_i;
    assign cfg_wr = wr && paddr_i == `TRIG_OFS_CFG;
    assign ctrl_wr = wr && paddr_i == `TRIG_OFS_CTRL;
    assign clr_pulse = ctrl_wr & pwdata_i[`TRIG_CTRL_CLR];

    always_comb begin
        known = 1'b1;
        case (paddr_i)
            `TRIG_OFS_CFG: rd_word = {chain_enable_r, tail_r, 4'h0, trig_now_r, 2'h0,
                                      wave_sel_r, 3'h0, pin_sel_r, iter_r};
            `TRIG_OFS_TARGET: rd_word = target_r;
            `TRIG_OFS_CYCW: rd_word = cycw_r;
            `TRIG_OFS_PAT: rd_word = {cnt_r, pat_r};
            `TRIG_OFS_PULW: rd_word = {16'h0000, pulw_r};
            `TRIG_OFS_CTRL: rd_word = {20'h00000, wave_r, st_r, 7'h00, unit_arm_r};
            `TRIG_OFS_RUNS: rd_word = runs_r;
            default: begin
                rd_word = `TRIG_RST_WORD;
                known = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= `TRIG_RST_WORD;
        end else if (psel_i & penable_i & ~pready_r) begin
            pready_r <= 1'b1;
            pslverr_r <= ~known;
            prdata_r <= pwrite_i ? `TRIG_RST_WORD : rd_word;
        end else begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            chain_enable_r <= 1'b0;
            tail_r <= 1'b0;
            trig_now_r <= 1'b0;
            wave_sel_r <= trig_out_pkg::WV_FALL;
            pin_sel_r <= 1'b0;
            iter_r <= `TRIG_RST_HALF;
        end else if (cfg_wr) begin
            chain_enable_r <= pwdata_i[`TRIG_CFG_CHAIN];
            tail_r <= pwdata_i[`TRIG_CFG_TAIL];
            trig_now_r <= pwdata_i[`TRIG_CFG_NOW];
            wave_sel_r <= trig_out_pkg::wave_sel_t'(pwdata_i[`TRIG_CFG_WAVE_HI:`TRIG_CFG_WAVE_LO]);
            pin_sel_r <= pwdata_i[`TRIG_CFG_PIN];
            iter_r <= pwdata_i[`TRIG_CFG_ITER_HI:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            target_r <= `TRIG_RST_WORD;
            cycw_r <= `TRIG_RST_WORD;
            cnt_r <= `TRIG_RST_HALF;
            pat_r <= `TRIG_RST_HALF;
            pulw_r <= `TRIG_RST_HALF;
        end else if (wr) begin
            if (paddr_i == `TRIG_OFS_TARGET) target_r <= pwdata_i;
            if (paddr_i == `TRIG_OFS_CYCW) cycw_r <= pwdata_i;
            if (paddr_i == `TRIG_OFS_PAT) begin
                cnt_r <= pwdata_i[31:16];
                pat_r <= pwdata_i[15:0];
            end
            if (paddr_i == `TRIG_OFS_PULW) pulw_r <= pwdata_i[15:0];
        end
    end

    // soft clear drops the arm, which is how an endless chain is stopped
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            unit_arm_r <= 1'b0;
        end else if (clr_pulse) begin
            unit_arm_r <= 1'b0; // [R18]
        end else if (ctrl_wr) begin
            unit_arm_r <= pwdata_i[`TRIG_CTRL_ARM];
        end
    end

    // ==========================================================
    // trigger time compare, wrap safe by signed difference
    logic reached, was_reached, fire, idle_lvl;
    logic [31:0] diff_now, diff_prev;

    assign diff_now = systime_i - target_r;
    assign diff_prev = prev_sys_r - target_r;
    assign reached = ~diff_now[31];
    assign was_reached = ~diff_prev[31];
    // without trigger-now a target already in the past never fires
    assign fire = st_r == trig_out_pkg::ST_IDLE && unit_arm_r &&
                  (trig_now_r ? reached : (reached & ~was_reached)); // [R01] [R17]
    assign idle_lvl = wave_sel_r == trig_out_pkg::WV_FALL || wave_sel_r == trig_out_pkg::WV_NPULSE ||
                      wave_sel_r == trig_out_pkg::WV_NPER;

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            prev_sys_r <= `TRIG_RST_WORD;
        end else begin
            prev_sys_r <= systime_i;
        end
    end

    // ==========================================================
    // phase timing: ns accumulate by the clock period, so a phase rounds up to whole clocks, at least one
    logic [31:0] pulse_ns, len, acc_sum, lim;
    logic ph_end, finite, last;

    assign pulse_ns = {13'h0000, pulw_r, 3'h0} ; // [R15]
    assign acc_sum = acc_r + CLK_NS;
    assign ph_end = acc_sum >= len;
    assign last = finite && (runs_r + 32'h0000_0001) == lim;

    always_comb begin
        len = cycw_r; // [R16]
        finite = cnt_r != `TRIG_RST_HALF;
        lim = {16'h0000, cnt_r};
        case (wave_sel_r)
            trig_out_pkg::WV_NPULSE, trig_out_pkg::WV_PPULSE: len = pulse_ns;
            trig_out_pkg::WV_NPER, trig_out_pkg::WV_PPER: begin
                if (!phase_r) len = (cycw_r > pulse_ns) ? cycw_r - pulse_ns : `TRIG_RST_WORD;
                else len = pulse_ns;
            end
            trig_out_pkg::WV_PATTERN: begin
                if (chain_enable_r && tail_r) begin
                    finite = 1'b1; // [R13]
                    lim = {11'h000, 17'(iter_r) + 17'h00001, 4'h0};
                end else if (chain_enable_r && !chain_tail_present_i) begin
                    finite = 1'b0; // [R14]
                end
            end
            default: len = cycw_r;
        endcase
    end

    // ==========================================================
    // waveform sequencer
    always_comb begin
        st_nxt = st_r;
        wave_nxt = wave_r;
        phase_nxt = phase_r;
        idx_nxt = idx_r;
        acc_nxt = acc_r;
        runs_nxt = runs_r;
        case (st_r)
            trig_out_pkg::ST_IDLE: begin
                wave_nxt = idle_lvl;
                acc_nxt = `TRIG_RST_WORD;
                runs_nxt = `TRIG_RST_WORD;
                idx_nxt = 4'h0;
                phase_nxt = 1'b1;
                if (fire) begin
                    st_nxt = trig_out_pkg::ST_RUN;
                    case (wave_sel_r)
                        trig_out_pkg::WV_FALL: begin
                            wave_nxt = 1'b0; // [R02]
                            st_nxt = trig_out_pkg::ST_DONE;
                        end
                        trig_out_pkg::WV_RISE: begin
                            wave_nxt = 1'b1; // [R03]
                            st_nxt = trig_out_pkg::ST_DONE;
                        end
                        trig_out_pkg::WV_PATTERN: wave_nxt = pat_r[`TRIG_PATTERN_BITS - 1]; // [R08]
                        // reserved code has no output: finish at idle
                        trig_out_pkg::WV_RSVD: st_nxt = trig_out_pkg::ST_DONE;
                        default: wave_nxt = ~idle_lvl; // [R04] [R05] [R06] [R07]
                    endcase
                end
            end
            trig_out_pkg::ST_RUN: begin
                acc_nxt = ph_end ? `TRIG_RST_WORD : acc_sum;
                if (ph_end) begin
                    case (wave_sel_r)
                        trig_out_pkg::WV_NPULSE, trig_out_pkg::WV_PPULSE: begin
                            wave_nxt = idle_lvl; // [R04] [R05] [R19]
                            st_nxt = trig_out_pkg::ST_DONE;
                        end
                        trig_out_pkg::WV_NPER, trig_out_pkg::WV_PPER: begin
                            phase_nxt = ~phase_r;
                            wave_nxt = phase_r ? idle_lvl : ~idle_lvl;
                            if (!phase_r) begin
                                runs_nxt = runs_r + 32'h0000_0001; // [R06] [R07]
                                if (last) begin
                                    wave_nxt = idle_lvl; // [R19]
                                    st_nxt = trig_out_pkg::ST_DONE;
                                end
                            end
                        end
                        trig_out_pkg::WV_PATTERN: begin
                            idx_nxt = idx_r + 4'h1;
                            runs_nxt = runs_r + 32'h0000_0001;
                            wave_nxt = pat_r[4'hF - idx_nxt]; // [R08]
                            if (last) begin
                                wave_nxt = 1'b0; // [R19]
                                st_nxt = trig_out_pkg::ST_DONE;
                            end
                        end
                        default: st_nxt = trig_out_pkg::ST_DONE;
                    endcase
                end
            end
            trig_out_pkg::ST_DONE: st_nxt = trig_out_pkg::ST_DONE;
            default: st_nxt = trig_out_pkg::ST_IDLE;
        endcase
        // reprogramming, rearming or disarming returns to idle
        if (clr_pulse || cfg_wr || !unit_arm_r ||
            (ctrl_wr && st_r == trig_out_pkg::ST_DONE)) begin
            st_nxt = trig_out_pkg::ST_IDLE;
            if (st_r != trig_out_pkg::ST_IDLE) wave_nxt = idle_lvl;
            // a new code starts at its own idle level, so a stale level never reaches a newly chosen pin
            if (cfg_wr) wave_nxt = ~pwdata_i[`TRIG_CFG_WAVE_LO] &
                                   (~&pwdata_i[`TRIG_CFG_WAVE_HI:`TRIG_CFG_WAVE_HI - 1]); // [R19]
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            st_r <= trig_out_pkg::ST_IDLE;
            wave_r <= 1'b1;
            phase_r <= 1'b1;
            idx_r <= 4'h0;
            acc_r <= `TRIG_RST_WORD;
            runs_r <= `TRIG_RST_WORD;
        end else begin
            st_r <= st_nxt;
            wave_r <= wave_nxt;
            phase_r <= phase_nxt;
            idx_r <= idx_nxt;
            acc_r <= acc_nxt;
            runs_r <= runs_nxt;
        end
    end

    // ==========================================================
    // pin routing, ORed with neighbouring units on the same pin
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            gpio1_r <= 1'b0;
            gpio2_r <= 1'b0;
        end else begin
            gpio1_r <= (~pin_sel_r & wave_r) | other_pin1_i; // [R11] [R12]
            gpio2_r <= (pin_sel_r & wave_r) | other_pin2_i; // [R11] [R12]
        end
    end

    assign gpio1_o = gpio1_r;
    assign gpio2_o = gpio2_r;
    assign prdata_o = prdata_r;
    assign pready_o = pready_r;
    assign pslverr_o = pslverr_r;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    AST_ARM_GATE: assert property ( // [R01]
        (st_r == trig_out_pkg::ST_IDLE && !unit_arm_r) |=> st_r != trig_out_pkg::ST_RUN)
        else $error("waveform started while unarmed");
    AST_FALL_EDGE: assert property ( // [R02]
        (fire && wave_sel_r == trig_out_pkg::WV_FALL && !clr_pulse && !wr) |=>
        (!wave_r && st_r == trig_out_pkg::ST_DONE))
        else $error("falling edge not produced");
    AST_RISE_EDGE: assert property ( // [R03]
        (fire && wave_sel_r == trig_out_pkg::WV_RISE && !clr_pulse && !wr) |=>
        (wave_r && st_r == trig_out_pkg::ST_DONE))
        else $error("rising edge not produced");
    AST_NEG_PULSE: assert property ( // [R04]
        (fire && wave_sel_r == trig_out_pkg::WV_NPULSE && pulw_r == 16'h0002 && !wr) |=>
        !wave_r ##1 wave_r)
        else $error("low pulse wrong");
    AST_POS_PULSE: assert property ( // [R05]
        (fire && wave_sel_r == trig_out_pkg::WV_PPULSE && pulw_r == 16'h0007 && !wr) |=>
        (wave_r && !wr) [*2] ##1 !wave_r)
        else $error("high pulse length wrong");
    AST_PERIOD_CNT: assert property ( // [R06]
        (st_r == trig_out_pkg::ST_RUN && wave_sel_r == trig_out_pkg::WV_NPER && cnt_r != 16'h0000) |->
        runs_r < {16'h0000, cnt_r})
        else $error("periodic cycle count overrun");
    AST_TAIL_PASSES: assert property ( // [R13]
        (st_r == trig_out_pkg::ST_RUN && wave_sel_r == trig_out_pkg::WV_PATTERN &&
         chain_enable_r && tail_r) |-> runs_r < lim)
        else $error("tail pattern passes overrun");
    AST_PIN_SEL: assert property ( // [R11]
        (pin_sel_r && !other_pin1_i) |=> !gpio1_o)
        else $error("first pin driven while second selected");
    AST_PIN_OR: assert property ( // [R12]
        other_pin2_i |=> gpio2_o)
        else $error("shared pin not ORed");
    AST_NOW_FIRE: assert property ( // [R17]
        (st_r == trig_out_pkg::ST_IDLE && unit_arm_r && trig_now_r && reached && !wr) |=>
        st_r != trig_out_pkg::ST_IDLE)
        else $error("trigger-now did not fire");
    AST_DONE_HOLD: assert property ( // [R19]
        (st_r == trig_out_pkg::ST_DONE && wave_sel_r == trig_out_pkg::WV_NPULSE) |-> wave_r)
        else $error("idle level not held after pulse");

endmodule // timed_trigger_waveform_output

// ### dv/pin_observer.sv
// far-side equipment model: counts edges and run lengths on one trigger pin
// assumes the pin is registered on clk_i, so one sample per clock sees every run
`timescale 1ns/1ps
module pin_observer (
    input wire logic clk_i,
    input wire logic clear_i,
    input wire logic line_i,
    output logic [7:0] rises_o,
    output logic [7:0] falls_o,
    output logic [7:0] last_hi_o,
    output logic [7:0] last_lo_o
);
    logic prev_r;
    logic [7:0] run_r;

    // ==========================================================
    // edge counts and widths of completed runs, in clocks
    // a run shorter than one clock cannot occur, so the pin stays under the toggle limit
    always_ff @(posedge clk_i) begin
        prev_r <= line_i;
        if (clear_i) begin
            rises_o <= 8'h0;
            falls_o <= 8'h0;
            last_hi_o <= 8'h0;
            last_lo_o <= 8'h0;
            run_r <= 8'h1;
        end else if (line_i != prev_r) begin
            run_r <= 8'h1;
            if (line_i) begin
                rises_o <= rises_o + 8'h1;
                last_lo_o <= run_r;
            end else begin
                falls_o <= falls_o + 8'h1;
                last_hi_o <= run_r;
            end
        end else begin
            run_r <= run_r + 8'h1;
        end
    end
endmodule // pin_observer

// ### dv/timed_trigger_waveform_output_tb.sv
// self-checking bench for the timed trigger output unit
// assumes a 20 MHz clock and a system time advancing 50 ns per clock
`timescale 1ns/1ps
`include "trig_out_regs.svh"
module timed_trigger_waveform_output_tb;
    typedef struct packed {
        logic [31:0] cfg;
        logic [15:0] pw;
        logic [31:0] cycw;
        logic [31:0] cntpat;
        logic [7:0] rises;
        logic [7:0] falls;
        logic [7:0] hi;
        logic [7:0] lo;
        logic fin;
        logic [31:0] runs;
    } row_t;
    localparam logic [31:0] no_runs = 32'hFFFFFFFF;
    // 8'hFF in hi or lo means not checked; code 111 is never programmed
    row_t rows [9] = '{
        '{32'h0, 16'h0, 32'h0, 32'h0, 8'h0, 8'h1, 8'hFF, 8'hFF, 1'h0, no_runs},
        '{32'h110000, 16'h0, 32'h0, 32'h0, 8'h1, 8'h0, 8'hFF, 8'hFF, 1'h1, no_runs},
        '{32'h200000, 16'h2, 32'h0, 32'h0, 8'h1, 8'h1, 8'hFF, 8'h1, 1'h1, no_runs},
        '{32'h310000, 16'h7, 32'h0, 32'h0, 8'h1, 8'h1, 8'h2, 8'hFF, 1'h0, no_runs},
        '{32'h400000, 16'hD, 32'h12C, 32'h30000, 8'h3, 8'h3, 8'h4, 8'h3, 1'h1, 32'h3},
        '{32'h510000, 16'h7, 32'hFA, 32'h20000, 8'h2, 8'h2, 8'h2, 8'h4, 1'h0, 32'h2},
        '{32'h600000, 16'h0, 32'h64, 32'h10A5F0, 8'h4, 8'h4, 8'hA, 8'h2, 1'h0, 32'h10},
        '{32'hC0600001, 16'h0, 32'h64, 32'hA5F0, 8'h8, 8'h8, 8'hA, 8'h2, 1'h0, 32'h20},
        '{32'h80600005, 16'h0, 32'h64, 32'h10A5F0, 8'h4, 8'h4, 8'hA, 8'h2, 1'h0, 32'h10}
    };
    logic clk, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, systime = 32'h0, prdata;
    logic pready, pslverr, gpio1, gpio2, obs_clear = 1'b0;
    logic tail_present = 1'b1, other1 = 1'b0, other2 = 1'b0;
    logic [7:0] r1, f1, h1, l1, r2, f2, h2, l2;
    logic [31:0] q;
    logic e;
    int n_fail = 0;
    int n_tests = 0;

    timed_trigger_waveform_output timed_trigger_waveform_output_i (.clk_i(clk), .reset_n_i(reset_n),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .systime_i(systime),
        .chain_tail_present_i(tail_present), .other_pin1_i(other1), .other_pin2_i(other2),
        .gpio1_o(gpio1), .gpio2_o(gpio2));
    pin_observer obs1_i (.clk_i(clk), .clear_i(obs_clear), .line_i(gpio1), .rises_o(r1), .falls_o(f1),
        .last_hi_o(h1), .last_lo_o(l1));
    pin_observer obs2_i (.clk_i(clk), .clear_i(obs_clear), .line_i(gpio2), .rises_o(r2), .falls_o(f2),
        .last_hi_o(h2), .last_lo_o(l2));

    // ==========================================================
    // clock, system time, watchdog
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) systime <= systime + 32'h32;
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        $display("[ERR] %0t watchdog expired", $time);
        close_out();
    end

    // ==========================================================
    // shared tasks
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s seen %h want %h", $time, what, seen, exp);
        end
    endtask
    // request held from setup until pready is sampled high, then released
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rq,
                       output logic re);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        chk(pready, 1'b1, "apb answer");
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rq;
        logic re;
        apb(1'b1, a, d, rq, re);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] rq);
        logic re;
        apb(1'b0, a, 32'h0, rq, re);
    endtask
    task automatic setup(input logic [31:0] cfg, input logic [15:0] pw, input logic [31:0] cycw,
                         input logic [31:0] cp, input logic [31:0] tgt);
        wr(`TRIG_OFS_CTRL, 32'h0);
        wr(`TRIG_OFS_CFG, cfg);
        wr(`TRIG_OFS_PULW, {16'h0, pw});
        wr(`TRIG_OFS_CYCW, cycw);
        wr(`TRIG_OFS_PAT, cp);
        wr(`TRIG_OFS_TARGET, tgt);
        obs_clear <= 1'b1;
        @(posedge clk);
        obs_clear <= 1'b0;
        wr(`TRIG_OFS_CTRL, 32'h1);
    endtask
    // polls the one-hot state field; the extra clocks cover the pin's one-edge lag
    task automatic wait_state(input logic [2:0] st);
        int n;
        logic [31:0] rq;
        n = 0;
        do begin
            rd(`TRIG_OFS_CTRL, rq);
            n++;
        end while (rq[10:8] !== st && n < 80);
        chk(rq[10:8], st, "unit state");
        repeat (2) @(posedge clk);
    endtask
    task automatic run_row(input row_t r);
        logic [31:0] rq;
        logic [7:0] ri, fa, hi, lo, ro, fo;
        setup(r.cfg, r.pw, r.cycw, r.cntpat, systime + 32'h7D0);
        wait_state(3'h4);
        {ri, fa, hi, lo, ro, fo} = r.cfg[`TRIG_CFG_PIN] ? {r2, f2, h2, l2, r1, f1} : {r1, f1, h1, l1, r2, f2};
        chk({ri, fa}, {r.rises, r.falls}, "edge counts");
        chk({ro, fo}, 16'h0, "unselected pin edges");
        chk(r.cfg[`TRIG_CFG_PIN] ? gpio2 : gpio1, r.fin, "final level");
        if (r.hi != 8'hFF) chk(hi, r.hi, "high width");
        if (r.lo != 8'hFF) chk(lo, r.lo, "low width");
        if (r.runs != no_runs) begin
            rd(`TRIG_OFS_RUNS, rq);
            chk(rq, r.runs, "runs emitted");
        end
    endtask

    // ==========================================================
    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 9; i++) begin
            run_row(rows[i]);
            $display("row %0d done", i);
        end
        other1 <= 1'b1;
        other2 <= 1'b1;
        repeat (2) @(posedge clk);
        chk(gpio1, 1'b1, "neighbour ored in");
        chk(gpio2, 1'b1, "second neighbour ored in");
        other1 <= 1'b0;
        other2 <= 1'b0;
        repeat (2) @(posedge clk);
        chk(gpio1, 1'b0, "neighbour released");
        chk(gpio2, 1'b0, "second neighbour released");
        $display("or test done");
        setup(32'h02310000, 16'h7, 32'h0, 32'h0, systime - 32'h3E8);
        wait_state(3'h4);
        chk(r2, 8'h1, "fire on past target");
        setup(32'h00310000, 16'h7, 32'h0, 32'h0, systime - 32'h3E8);
        repeat (20) @(posedge clk);
        rd(`TRIG_OFS_CTRL, q);
        chk({q[10:8], r2}, {3'h1, 8'h0}, "no fire on past target");
        $display("trigger now test done");
        tail_present <= 1'b0;
        setup(32'h80600000, 16'h0, 32'h64, 32'h1A5F0, systime + 32'h7D0);
        wait_state(3'h2);
        repeat (100) @(posedge clk);
        rd(`TRIG_OFS_RUNS, q);
        chk(q > 32'h10, 1'b1, "endless chain runs on");
        wr(`TRIG_OFS_CTRL, 32'h2); // stop the endless loop
        rd(`TRIG_OFS_CTRL, q);
        chk({q[10:8], q[0]}, {3'h1, 1'b0}, "soft clear to idle");
        $display("endless chain test done");
        reset_n <= 1'b0;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk({gpio2, gpio1}, 2'b01, "pins after reset");
        rd(`TRIG_OFS_CTRL, q);
        chk(q, 32'h900, "ctrl after reset");
        rd(`TRIG_OFS_RUNS, q);
        chk(q, 32'h0, "runs after reset");
        apb(1'b0, 8'h1C, 32'h0, q, e);
        chk({q, e}, {32'h0, 1'b1}, "unmapped read");
        apb(1'b1, 8'h1C, 32'hFFFFFFFF, q, e);
        chk(e, 1'b1, "unmapped write");
        wr(`TRIG_OFS_CFG, 32'hFFEFFFFF);
        rd(`TRIG_OFS_CFG, q);
        chk(q, 32'hC261FFFF, "cfg reserved bits");
        $display("reset and register test done");
        close_out();
    end
endmodule // timed_trigger_waveform_output_tb
